// file: logic/cgms_pkg.sv
// Package with register map, field positions, reset values and timing of the clock generator.
// Behaviour
// - Control two bits 7:6 hold output divider; 00 passes clock undivided.
// - Control two bit 5 selects high-frequency oscillator range.
// - Control two bit 4 selects high-gain oscillator operation.
// - Control two bit 2 selects crystal as external reference, starts start-up.
// - Control two bit 1 keeps external reference clock active.
// - Status bit 1 sets once chosen oscillator finished initialization.
// - Control one bits 7:6 pick output source: loop, internal, external.
// - Control one bits 5:3 set reference divider as power of two.
// - Control one bit 2 picks loop reference: 1 internal, 0 external.
// - Status bit 4 reports reference actually feeding the loop.
// - Status bits 3:2 report clock actually driving generator output.
// - Control two bit 3 in bypass enters low-power bypass, loops disabled.
// - Control three bit 6 picks PLL or FLL; low-power bypass only prepares.
// - Control three bits 3:0 set PLL multiplier; 0100 means times 16.
// - Status bit 5 is 1 when PLL is current loop source.
// - Status bit 6 sets when the selected loop has acquired lock.
// - In ordinary bypass modes the selected loop, FLL or PLL, stays enabled and running.
// - PLL output equals ext divided by R times M over B; bus half.
// - Reset starts in internal FLL engaged mode with divide by two.
package cgms_pkg;
    localparam logic [1:0] ADDR_CLK_SEL = 2'h0;
    localparam logic [1:0] ADDR_OSC = 2'h1;
    localparam logic [1:0] ADDR_LOOP = 2'h2;
    localparam logic [1:0] ADDR_STATE = 2'h3;
    localparam logic [7:0] CLK_SEL_RST = 8'h04;
    localparam logic [7:0] OSC_RST = 8'h40;
    localparam logic [7:0] LOOP_RST = 8'h01;
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 6;
    localparam int REF_DIVIDER_HI = 5;
    localparam int REF_DIVIDER_LO = 3;
    localparam int IREF_BIT = 2;
    localparam int OUTPUT_DIVIDER_HI = 7;
    localparam int OUTPUT_DIVIDER_LO = 6;
    localparam int RANGE_BIT = 5;
    localparam int HGO_BIT = 4;
    localparam int LP_BIT = 3;
    localparam int EREF_BIT = 2;
    localparam int ERCLK_BIT = 1;
    localparam int LOOP_SELECT_BIT = 6;
    localparam int MUL_HI = 3;
    localparam int ST_LOCK = 6;
    localparam int ST_LOOP_SELECT = 5;
    localparam int ST_IREF = 4;
    localparam int ST_CLK_HI = 3;
    localparam int ST_OSC = 1;
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SRC_INT = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] CST_FLL = 2'h0;
    localparam logic [1:0] CST_INT = 2'h1;
    localparam logic [1:0] CST_EXT = 2'h2;
    localparam logic [1:0] CST_PLL = 2'h3;
    // Settle times in nanoseconds, converted to 200 MHz cycles.
    localparam int CLK_PERIOD_NS = 5;
    localparam int OSC_START_NS = 20000;
    localparam int LOCK_NS = 10000;
    localparam int SWITCH_NS = 40;
    localparam int OSC_START_CYC = OSC_START_NS / CLK_PERIOD_NS;
    localparam int LOCK_CYC = LOCK_NS / CLK_PERIOD_NS;
    localparam int SWITCH_CYC = (SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    typedef enum logic [1:0] {
        CGMS_ENGAGED = 2'b00,
        CGMS_BYPASS = 2'b01,
        CGMS_LOWPWR = 2'b10
    } cgms_mode_t;
endpackage

// file: logic/cgms_top.sv
// Clock generator mode controller with its control and status registers.
`timescale 1ns/1ps
module cgms_top #(
    parameter int OSC_START_CYCLES = cgms_pkg::OSC_START_CYC,
    parameter int LOCK_CYCLES = cgms_pkg::LOCK_CYC
) (
    // Clock and reset.
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    // Register port.
    input wire logic [1:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [7:0] RDATA_OUT,
    // Clock controls toward the analog blocks.
    output logic [1:0] OUT_CLK_STATE_OUT,
    output logic [1:0] OUTPUT_DIVIDER_OUT,
    output logic [2:0] REF_DIVIDER_OUT,
    output logic [3:0] PLL_MULTIPLIER_OUT,
    output logic OSC_RANGE_HIGH_OUT,
    output logic OSC_HIGH_GAIN_OUT,
    output logic EXT_REF_CLK_ENABLE_OUT,
    output logic FLL_ENABLE_OUT,
    output logic PLL_ENABLE_OUT,
    output logic LOOP_REF_INT_OUT
);
    logic [7:0] clk_sel_r;
    logic [7:0] osc_r;
    logic [7:0] loop_r;
    logic osc_ready_r;
    logic iref_st_r;
    logic pll_st_r;
    logic lock_r;
    logic [1:0] clk_st_r;
    logic [cgms_pkg::CNT_W-1:0] osc_cnt_r;
    logic [cgms_pkg::CNT_W-1:0] lock_cnt_r;
    logic [cgms_pkg::CNT_W-1:0] sw_cnt_r;
    logic [7:0] rdata_r;
    logic [1:0] out_state_r;
    logic [1:0] output_divider_out_r;
    logic [2:0] ref_divider_out_r;
    logic [3:0] mul_out_r;
    logic range_out_r;
    logic hgo_out_r;
    logic erclk_out_r;
    logic fll_en_r;
    logic pll_en_r;
    logic ref_int_r;

    wire wr_sel = WR_IN && (ADDR_IN == cgms_pkg::ADDR_CLK_SEL);
    wire wr_osc = WR_IN && (ADDR_IN == cgms_pkg::ADDR_OSC);
    wire wr_loop = WR_IN && (ADDR_IN == cgms_pkg::ADDR_LOOP);
    wire [1:0] src_req = clk_sel_r[cgms_pkg::SRC_HI:cgms_pkg::SRC_LO];
    wire iref_req = clk_sel_r[cgms_pkg::IREF_BIT];
    wire lp_req = osc_r[cgms_pkg::LP_BIT];
    wire ext_used = osc_r[cgms_pkg::EREF_BIT];
    wire ext_active = osc_r[cgms_pkg::ERCLK_BIT] || !iref_req || (src_req == cgms_pkg::SRC_EXT);
    wire pll_req = loop_r[cgms_pkg::LOOP_SELECT_BIT];
    wire bypass = (src_req != cgms_pkg::SRC_LOOP);
    // Loops are stopped only in low-power bypass; ordinary bypass keeps the selected loop running.
    wire lowpower = bypass && lp_req;
    // Loop switches are held back in low-power bypass so the change only prepares the mode.
    wire loop_switch = !lowpower && (pll_req != pll_st_r);
    wire [1:0] want_st = (src_req == cgms_pkg::SRC_INT) ? cgms_pkg::CST_INT :
                         (src_req == cgms_pkg::SRC_EXT) ? cgms_pkg::CST_EXT :
                         (pll_st_r ? cgms_pkg::CST_PLL : cgms_pkg::CST_FLL);
    wire ref_change = (iref_req != iref_st_r) || (want_st != clk_st_r) || loop_switch;
    wire [7:0] status = {1'b0, lock_r, pll_st_r, iref_st_r, clk_st_r, osc_ready_r, 1'b0};
    wire [7:0] rd_mux = (ADDR_IN == cgms_pkg::ADDR_CLK_SEL) ? clk_sel_r :
                        (ADDR_IN == cgms_pkg::ADDR_OSC) ? osc_r :
                        (ADDR_IN == cgms_pkg::ADDR_LOOP) ? loop_r : status;
    wire osc_done = (osc_cnt_r >= OSC_START_CYCLES[cgms_pkg::CNT_W-1:0]);
    wire lock_done = (lock_cnt_r >= LOCK_CYCLES[cgms_pkg::CNT_W-1:0]);
    wire sw_done = (sw_cnt_r >= cgms_pkg::SWITCH_CYC[cgms_pkg::CNT_W-1:0]);
    wire cgms_pkg::cgms_mode_t mode_nxt = lowpower ? cgms_pkg::CGMS_LOWPWR :
                                         (bypass ? cgms_pkg::CGMS_BYPASS : cgms_pkg::CGMS_ENGAGED);
    // Only the low-power mode stops the loops, so the enables follow the next mode directly.
    wire fll_run = (mode_nxt != cgms_pkg::CGMS_LOWPWR) && !pll_st_r;
    wire pll_run = (mode_nxt != cgms_pkg::CGMS_LOWPWR) && pll_st_r;

    // Control registers; reset values give internal FLL engaged with divide by two.
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            clk_sel_r <= cgms_pkg::CLK_SEL_RST;
            osc_r <= cgms_pkg::OSC_RST;
            loop_r <= cgms_pkg::LOOP_RST;
        end
        else
        begin
            if (wr_sel)
                clk_sel_r <= WDATA_IN;
            if (wr_osc)
                osc_r <= WDATA_IN;
            if (wr_loop)
                loop_r <= {1'b0, WDATA_IN[6:0]};
        end
    end

    // Oscillator start-up: ready only after a full count with the crystal requested.
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            osc_cnt_r <= '0;
        else if (!(ext_used && ext_active))
            osc_cnt_r <= '0;
        else if (!osc_done)
            osc_cnt_r <= osc_cnt_r + 1'b1;
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            osc_ready_r <= 1'b0;
        else
            osc_ready_r <= ext_used && ext_active && osc_done;
    end

    // Switch settle timer; every reference, loop and output-source status change waits for it so muxing stays glitch-free.
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            sw_cnt_r <= '0;
        else if (!ref_change || sw_done)
            sw_cnt_r <= '0;
        else
            sw_cnt_r <= sw_cnt_r + 1'b1;
    end

    // Status of reference, loop and output source.
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            iref_st_r <= 1'b1;
            pll_st_r <= 1'b0;
            clk_st_r <= cgms_pkg::CST_FLL;
        end
        else if (sw_done)
        begin
            iref_st_r <= iref_req;
            if (!lowpower)
                pll_st_r <= pll_req;
            clk_st_r <= want_st;
        end
    end

    // Lock timer restarts on any reference or loop change and while loops are stopped.
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            lock_cnt_r <= '0;
        else if (lowpower || ref_change || (!iref_st_r && !osc_ready_r))
            lock_cnt_r <= '0;
        else if (!lock_done)
            lock_cnt_r <= lock_cnt_r + 1'b1;
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
            lock_r <= 1'b0;
        else
            lock_r <= lock_done && !lowpower && !ref_change;
    end

    // Registered outputs feeding the analog clock path.
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (RST_IN)
        begin
            rdata_r <= 8'h00;
            out_state_r <= cgms_pkg::CST_FLL;
            output_divider_out_r <= cgms_pkg::OSC_RST[cgms_pkg::OUTPUT_DIVIDER_HI:cgms_pkg::OUTPUT_DIVIDER_LO];
            ref_divider_out_r <= 3'h0;
            mul_out_r <= 4'h1;
            range_out_r <= 1'b0;
            hgo_out_r <= 1'b0;
            erclk_out_r <= 1'b0;
            fll_en_r <= 1'b1;
            pll_en_r <= 1'b0;
            ref_int_r <= 1'b1;
        end
        else
        begin
            rdata_r <= RD_IN ? rd_mux : 8'h00;
            out_state_r <= clk_st_r;
            output_divider_out_r <= osc_r[cgms_pkg::OUTPUT_DIVIDER_HI:cgms_pkg::OUTPUT_DIVIDER_LO];
            ref_divider_out_r <= clk_sel_r[cgms_pkg::REF_DIVIDER_HI:cgms_pkg::REF_DIVIDER_LO];
            mul_out_r <= loop_r[cgms_pkg::MUL_HI:0];
            range_out_r <= osc_r[cgms_pkg::RANGE_BIT];
            hgo_out_r <= osc_r[cgms_pkg::HGO_BIT];
            erclk_out_r <= ext_active;
            fll_en_r <= fll_run;
            pll_en_r <= pll_run;
            ref_int_r <= iref_st_r;
        end
    end

    assign RDATA_OUT = rdata_r;
    assign OUT_CLK_STATE_OUT = out_state_r;
    assign OUTPUT_DIVIDER_OUT = output_divider_out_r;
    assign REF_DIVIDER_OUT = ref_divider_out_r;
    assign PLL_MULTIPLIER_OUT = mul_out_r;
    assign OSC_RANGE_HIGH_OUT = range_out_r;
    assign OSC_HIGH_GAIN_OUT = hgo_out_r;
    assign EXT_REF_CLK_ENABLE_OUT = erclk_out_r;
    assign FLL_ENABLE_OUT = fll_en_r;
    assign PLL_ENABLE_OUT = pll_en_r;
    assign LOOP_REF_INT_OUT = ref_int_r;
endmodule

// file: dv/cgms_props.sv
// Port-level assertions for the clock generator mode controller.
`timescale 1ns/1ps
module cgms_props (
    // Clock, reset and register port.
    input wire logic CORE_CLK_IN,
    input wire logic RST_IN,
    input wire logic [1:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [7:0] RDATA_OUT,
    // Clock controls.
    input wire logic [1:0] OUT_CLK_STATE_OUT,
    input wire logic [1:0] OUTPUT_DIVIDER_OUT,
    input wire logic [2:0] REF_DIVIDER_OUT,
    input wire logic [3:0] PLL_MULTIPLIER_OUT,
    input wire logic OSC_RANGE_HIGH_OUT,
    input wire logic OSC_HIGH_GAIN_OUT,
    input wire logic EXT_REF_CLK_ENABLE_OUT,
    input wire logic FLL_ENABLE_OUT,
    input wire logic PLL_ENABLE_OUT,
    input wire logic LOOP_REF_INT_OUT
);
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    sequence sel_wr_s;
        WR_IN && ADDR_IN == cgms_pkg::ADDR_CLK_SEL;
    endsequence
    // A source switch must not show before the clocks have had time to settle.
    sequence hold_s;
        $stable(OUT_CLK_STATE_OUT) [*8];
    endsequence
    rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
        else $error("read data not zero outside a read");
    out_div_a: assert property (WR_IN && ADDR_IN == cgms_pkg::ADDR_OSC |->
        ##2 OUTPUT_DIVIDER_OUT == $past(WDATA_IN[7:6], 2)) else $error("output divider wrong");
    ref_div_a: assert property (sel_wr_s |->
        ##2 REF_DIVIDER_OUT == $past(WDATA_IN[5:3], 2)) else $error("reference divider wrong");
    pll_mul_a: assert property (WR_IN && ADDR_IN == cgms_pkg::ADDR_LOOP |->
        ##2 PLL_MULTIPLIER_OUT == $past(WDATA_IN[3:0], 2)) else $error("multiplier wrong");
    switch_settle_a: assert property (sel_wr_s |=> hold_s)
        else $error("clock state changed before settling");
    fll_run_a: assert property (OUT_CLK_STATE_OUT == cgms_pkg::CST_FLL |-> FLL_ENABLE_OUT)
        else $error("FLL drives output while disabled");
    pll_run_a: assert property (OUT_CLK_STATE_OUT == cgms_pkg::CST_PLL |-> PLL_ENABLE_OUT)
        else $error("PLL drives output while disabled");
    ext_run_a: assert property (OUT_CLK_STATE_OUT == cgms_pkg::CST_EXT |->
        EXT_REF_CLK_ENABLE_OUT) else $error("external clock drives output while off");
endmodule
bind cgms_top cgms_props cgms_props_inst (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
    .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .OUT_CLK_STATE_OUT(OUT_CLK_STATE_OUT),
    .OUTPUT_DIVIDER_OUT(OUTPUT_DIVIDER_OUT), .REF_DIVIDER_OUT(REF_DIVIDER_OUT),
    .PLL_MULTIPLIER_OUT(PLL_MULTIPLIER_OUT), .OSC_RANGE_HIGH_OUT(OSC_RANGE_HIGH_OUT),
    .OSC_HIGH_GAIN_OUT(OSC_HIGH_GAIN_OUT), .EXT_REF_CLK_ENABLE_OUT(EXT_REF_CLK_ENABLE_OUT),
    .FLL_ENABLE_OUT(FLL_ENABLE_OUT), .PLL_ENABLE_OUT(PLL_ENABLE_OUT),
    .LOOP_REF_INT_OUT(LOOP_REF_INT_OUT));

// file: dv/cgms_top_tb.sv
// Self-checking testbench walking the clock generator from reset through PLL engaged to internal bypass.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module cgms_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, rv;
    logic [1:0] cst, output_divider;
    logic [2:0] ref_divider;
    logic [3:0] mul;
    logic rng, gain, ext_en, fll_en, pll_en, ref_int;
    int errors = 0;
    int cmp_count = 0;
    cgms_top #(.OSC_START_CYCLES(20), .LOCK_CYCLES(10)) cgms_top_inst (
        .CORE_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .OUT_CLK_STATE_OUT(cst), .OUTPUT_DIVIDER_OUT(output_divider),
        .REF_DIVIDER_OUT(ref_divider), .PLL_MULTIPLIER_OUT(mul), .OSC_RANGE_HIGH_OUT(rng),
        .OSC_HIGH_GAIN_OUT(gain), .EXT_REF_CLK_ENABLE_OUT(ext_en), .FLL_ENABLE_OUT(fll_en),
        .PLL_ENABLE_OUT(pll_en), .LOOP_REF_INT_OUT(ref_int));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Status polling is bounded so a stuck flag ends the run instead of hanging it.
    task automatic poll(input logic [7:0] mask, input logic [7:0] val, input string nm);
        int n;
        n = 0;
        rd_reg(cgms_pkg::ADDR_STATE, rv);
        while ((rv & mask) !== val && n < 300)
        begin
            rd_reg(cgms_pkg::ADDR_STATE, rv);
            n++;
        end
        `CHK(nm, val, rv & mask)
        if (n >= 300)
            print_verdict();
    endtask
    task automatic t_reset();
        rd_reg(cgms_pkg::ADDR_CLK_SEL, rv);
        `CHK("clk_sel", cgms_pkg::CLK_SEL_RST, rv)
        rd_reg(cgms_pkg::ADDR_OSC, rv);
        `CHK("osc", cgms_pkg::OSC_RST, rv)
        rd_reg(cgms_pkg::ADDR_STATE, rv);
        `CHK("state", 8'h10, rv)
        `CHK("output_divider", 2'h1, output_divider)
        `CHK("ref_int", 1'b1, ref_int)
        $display("done reset");
    endtask
    task automatic t_fbe();
        wr_reg(cgms_pkg::ADDR_OSC, 8'h36);
        poll(8'h02, 8'h02, "osc_ready");
        `CHK("output_divider", 2'h0, output_divider)
        `CHK("range", 1'b1, rng)
        `CHK("gain", 1'b1, gain)
        `CHK("ext_en", 1'b1, ext_en)
        wr_reg(cgms_pkg::ADDR_CLK_SEL, 8'hB8);
        poll(8'h1C, 8'h08, "ext_bypass");
        `CHK("ref_divider", 3'h7, ref_divider)
        `CHK("ref_int", 1'b0, ref_int)
        poll(8'h40, 8'h40, "fll_lock");
        `CHK("fll_en", 1'b1, fll_en)
        $display("done ext bypass");
    endtask
    task automatic t_lowpower();
        wr_reg(cgms_pkg::ADDR_OSC, 8'h3E);
        wr_reg(cgms_pkg::ADDR_CLK_SEL, 8'h90);
        wr_reg(cgms_pkg::ADDR_LOOP, 8'h44);
        rd_reg(cgms_pkg::ADDR_STATE, rv);
        `CHK("pll_st", 8'h00, rv & 8'h60)
        `CHK("fll_en", 1'b0, fll_en)
        `CHK("pll_en", 1'b0, pll_en)
        `CHK("ref_divider", 3'h2, ref_divider)
        `CHK("mul", 4'h4, mul)
        wr_reg(cgms_pkg::ADDR_OSC, 8'h36);
        poll(8'h20, 8'h20, "pll_st");
        poll(8'h40, 8'h40, "pll_lock");
        `CHK("pll_en", 1'b1, pll_en)
        $display("done low power");
    endtask
    task automatic t_pll();
        wr_reg(cgms_pkg::ADDR_CLK_SEL, 8'h10);
        poll(8'h0C, 8'h0C, "pll_out");
        // The source switch restarts the lock count, so wait for lock before reading status.
        poll(8'h40, 8'h40, "pee_lock");
        wr_reg(cgms_pkg::ADDR_STATE, 8'hFF);
        wr_reg(cgms_pkg::ADDR_LOOP, 8'hC4);
        rd_reg(cgms_pkg::ADDR_LOOP, rv);
        `CHK("loop", 8'h44, rv)
        rd_reg(cgms_pkg::ADDR_STATE, rv);
        `CHK("state", 8'h6E, rv)
        `CHK("cst", cgms_pkg::CST_PLL, cst)
        $display("done pll engaged");
    endtask
    task automatic t_fbi();
        wr_reg(cgms_pkg::ADDR_CLK_SEL, 8'h44);
        poll(8'h1C, 8'h14, "int_bypass");
        `CHK("cst", cgms_pkg::CST_INT, cst)
        `CHK("ref_int", 1'b1, ref_int)
        $display("done int bypass");
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fbe();
        t_lowpower();
        t_pll();
        t_fbi();
        print_verdict();
    end
endmodule
